/* verilog/led_serial_regs.svh */
// Purpose: Constants shared by both ends of the LED driver serial link.
// Assumes: System clock of 40 MHz; link words of 16 bits.
// Notes: Definitions only; included by its bare name.
//
// Overview of operation
// - 16-bit words, MSB first: flag, address, data.
// - Flag low: store data byte at address.
// - Flag high: read address, discard data byte.
// - Keep only the latest 16 shifted bits.
// - Chip select rising copies shift bits to latch.
// - Read loads register into shift low byte.
// - Host reads reply's second byte next command.
// - Input reappears at output 15.5 clocks later.
// - Chain of n devices needs 16n clocks.
// - Chip select low enables the shift register.
// - Clock low around chip select edges.
// - Config bit 7 clear selects serial output.
// - Pin power-up function depends on variant.
// - Host reconfigures pin before any read.
// - Daisy-chained clock at most 17.5 MHz.
// - Sample input on rising clock, selected only.
// - Ignore clock and input while deselected.
// - Serial output is always driven; the code releases the pin while config bit 7 is set.
`ifndef LED_SERIAL_REGS_SVH
`define LED_SERIAL_REGS_SVH

`define WORD_BITS 16
`define RW_BIT 15
`define ADDR_HI 14
`define ADDR_LO 8
`define DATA_HI 7
`define DATA_LO 0
`define ADDR_BITS 7
`define DATA_BITS 8
`define REG_COUNT 128
`define WORD_RESET 16'h0000
`define CFG_ADDR 7'h10
`define CFG_PIN_BIT 7

`define CLK_PERIOD_NS 25
`define SCLK_MAX_KHZ 17500
`define HOST_HALF_MIN ((1000000 + 2 * `SCLK_MAX_KHZ * `CLK_PERIOD_NS - 1) / (2 * `SCLK_MAX_KHZ * `CLK_PERIOD_NS))
`define HOST_HALF (`HOST_HALF_MIN + 2)
`define HOST_GAP 8

`endif

/* verilog/led_serial_pkg.sv */
// Purpose: Types and word decoding shared by both link ends.
// Assumes: Field positions from the constants header.
// Notes: None.
`include "led_serial_regs.svh"
package led_serial_pkg;

   typedef logic [`WORD_BITS-1:0] word_t;
   typedef logic [`ADDR_BITS-1:0] addr_t;
   typedef logic [`DATA_BITS-1:0] data_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_HIGH,
      ST_LOW,
      ST_TRAIL,
      ST_GAP
   } host_state_e;

   function automatic logic word_is_read(input word_t w);
      return w[`RW_BIT];
   endfunction

   function automatic addr_t word_addr(input word_t w);
      return w[`ADDR_HI:`ADDR_LO];
   endfunction

   function automatic data_t word_data(input word_t w);
      return w[`DATA_HI:`DATA_LO];
   endfunction

endpackage

/* verilog/led_serial_if.sv */
// Purpose: Four-wire link between the serial host and the LED device.
// Assumes: The bench drives pwm_src as the external PWM clock source.
// Notes: Resolves the dual-purpose pin from the device's output enable.
`timescale 1ns/1ps
`default_nettype none
interface led_serial_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic pin_out;
   logic pin_oe_n;
   logic pwm_src;
   logic pin_level;
   logic pin_in;

   // The device drives the pin while pin_oe_n is low; otherwise the
   // external PWM clock source owns it.
   assign pin_level = pin_oe_n ? pwm_src : pin_out;
   assign pin_in = pin_level;

   modport dev (
      input sclk,
      input cs_n,
      input sdi,
      input pin_in,
      output pin_out,
      output pin_oe_n
   );

   modport host (
      output sclk,
      output cs_n,
      output sdi,
      input pin_level
   );
endinterface
`default_nettype wire

/* verilog/led_serial_device.sv */
// Purpose: Serial slave port of the LED driver, with its register array.
// Assumes: Link logic runs on the serial clock; the rest on clk.
// Notes: Chip select high is the hand-over point between the domains.
`timescale 1ns/1ps
`default_nettype none
module led_serial_device
   import led_serial_pkg::*;
#(
   parameter bit PIN_STARTS_AS_SOUT = 1'b1
)
(
   input wire logic clk,
   input wire logic arst_n,
   led_serial_if.dev link,
   output logic [15:0] latched_word,
   output logic wr_pulse,
   output logic [6:0] wr_addr,
   output logic [7:0] wr_data,
   output logic pin_is_sout,
   output logic pwm_clock_input
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   word_t shift_ff;
   word_t nxt_shift;
   word_t shift_view;
   logic first_ff;
   logic sout_ff;
   logic merge_rd;

   logic cs_meta_ff;
   logic cs_sync_ff;
   logic cs_prev_ff;
   logic cs_rise;
   word_t cmd_ff;
   logic rd_pending_ff;
   data_t rd_byte_ff;
   data_t rd_lookup;
   logic wr_pulse_ff;
   addr_t wr_addr_ff;
   data_t wr_data_ff;
   logic cfg_pin_ff;
   logic pin_oe_n_ff;
   logic pin_sout_ff;
   logic pwm_meta_ff;
   logic pwm_sync_ff;
   data_t regs_mem [`REG_COUNT];

   logic new_is_read;
   addr_t new_addr;
   data_t new_data;
   logic new_is_cfg;

   // ------------------------------------------------------------
   // Serial clock domain: shift register and serial output
   // ------------------------------------------------------------
   // A read result is not written into the shift register at the
   // chip select edge, because the serial clock is stopped then.
   // Instead it is merged at the first rising edge of the next frame,
   // which is before any of the low eight positions can reach the
   // output, so the reply stream is the same.
   assign merge_rd = first_ff & rd_pending_ff;
   assign shift_view = merge_rd ?
      {shift_ff[`WORD_BITS-1:`DATA_BITS], rd_byte_ff} : shift_ff;
   assign nxt_shift = {shift_view[`WORD_BITS-2:0], link.sdi};

   // Bits are kept across frames; only the newest sixteen survive.
   always_ff @(posedge link.sclk or negedge arst_n)
   begin
      if (!arst_n)
         shift_ff <= `WORD_RESET;
      else if (!link.cs_n)
         shift_ff <= nxt_shift;
   end

   // Marks the first rising edge of a frame; chip select high ends
   // the frame, so no serial clock edge is needed to rearm it.
   always_ff @(posedge link.sclk or posedge link.cs_n)
   begin
      if (link.cs_n)
         first_ff <= 1'b1;
      else
         first_ff <= 1'b0;
   end

   // The newest bit shifts to the top after fifteen more rising edges
   // and leaves on the falling edge after that.
   always_ff @(negedge link.sclk or negedge arst_n)
   begin
      if (!arst_n)
         sout_ff <= 1'b0;
      else if (!link.cs_n)
         sout_ff <= shift_ff[`WORD_BITS-1];
   end

   // The output keeps its last level while deselected, never floats.
   assign link.pin_out = sout_ff;
   assign link.pin_oe_n = pin_oe_n_ff;

   // ------------------------------------------------------------
   // System clock domain: chip select edge detection
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_meta_ff <= 1'b1;
         cs_sync_ff <= 1'b1;
         cs_prev_ff <= 1'b1;
      end
      else
      begin
         cs_meta_ff <= link.cs_n;
         cs_sync_ff <= cs_meta_ff;
         cs_prev_ff <= cs_sync_ff;
      end
   end

   assign cs_rise = cs_sync_ff & ~cs_prev_ff;

   // ------------------------------------------------------------
   // Command latch and decode
   // ------------------------------------------------------------
   // The shift register is quiet while chip select is high, so it is
   // safe to copy it as a word once the rising edge has synchronised.
   assign new_is_read = word_is_read(shift_ff);
   assign new_addr = word_addr(shift_ff);
   assign new_data = word_data(shift_ff);
   assign new_is_cfg = (new_addr == `CFG_ADDR);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cmd_ff <= `WORD_RESET;
      else if (cs_rise)
         cmd_ff <= shift_ff;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_pending_ff <= 1'b0;
      else if (cs_rise)
         rd_pending_ff <= new_is_read;
   end

   // ------------------------------------------------------------
   // Register array and write strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (cs_rise && !new_is_read)
         regs_mem[new_addr] <= new_data;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_pulse_ff <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
      end
      else
      begin
         wr_pulse_ff <= cs_rise & ~new_is_read;
         if (cs_rise && !new_is_read)
         begin
            wr_addr_ff <= new_addr;
            wr_data_ff <= new_data;
         end
      end
   end

   // The pin select bit has its own flip-flop so that it has a reset
   // value; the array itself is plain storage without reset.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cfg_pin_ff <= ~PIN_STARTS_AS_SOUT;
      else if (cs_rise && !new_is_read && new_is_cfg)
         cfg_pin_ff <= new_data[`CFG_PIN_BIT];
   end

   // The dummy data byte of a read is dropped; only the address counts.
   assign rd_lookup = new_is_cfg ?
      {cfg_pin_ff, regs_mem[new_addr][`CFG_PIN_BIT-1:0]} :
      regs_mem[new_addr];

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_byte_ff <= '0;
      else if (cs_rise && new_is_read)
         rd_byte_ff <= rd_lookup;
   end

   // ------------------------------------------------------------
   // Dual-purpose pin
   // ------------------------------------------------------------
   // A second flop carries the select flag so that the user output
   // comes straight from a register rather than through an inverter.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_oe_n_ff <= ~PIN_STARTS_AS_SOUT;
         pin_sout_ff <= PIN_STARTS_AS_SOUT;
      end
      else
      begin
         pin_oe_n_ff <= cfg_pin_ff;
         pin_sout_ff <= ~cfg_pin_ff;
      end
   end

   // The PWM clock arrives from outside; two flip-flops before use.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pwm_meta_ff <= 1'b0;
         pwm_sync_ff <= 1'b0;
      end
      else
      begin
         pwm_meta_ff <= link.pin_in & pin_oe_n_ff;
         pwm_sync_ff <= pwm_meta_ff;
      end
   end

   // ------------------------------------------------------------
   // User-side outputs
   // ------------------------------------------------------------
   assign latched_word = cmd_ff;
   assign wr_pulse = wr_pulse_ff;
   assign wr_addr = wr_addr_ff;
   assign wr_data = wr_data_ff;
   assign pin_is_sout = pin_sout_ff;
   assign pwm_clock_input = pwm_sync_ff;

endmodule
`default_nettype wire

/* verilog/led_serial_host.sv */
// Purpose: Serial host that sends one 16-bit word per request.
// Assumes: Makes the serial clock from clk by a divider.
// Notes: The reply word is the device output captured during the frame.
`timescale 1ns/1ps
`default_nettype none
module led_serial_host
   import led_serial_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   led_serial_if.host link,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_word
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   host_state_e state_ff;
   logic [3:0] cnt_ff;
   logic [4:0] bit_ff;
   word_t tx_ff;
   word_t rx_ff;
   logic sclk_ff;
   logic cs_n_ff;
   logic ready_ff;
   logic rsp_valid_ff;
   word_t rsp_ff;
   logic din_meta_ff;
   logic din_sync_ff;
   logic half_done;
   logic gap_done;
   logic last_bit;

   // The half period leaves two cycles beyond the chain speed limit so
   // that the synchronised input has settled before each rising edge.
   assign half_done = (cnt_ff == 4'(`HOST_HALF - 1));
   assign gap_done = (cnt_ff == 4'(`HOST_GAP - 1));
   assign last_bit = (bit_ff == 5'(`WORD_BITS - 1));

   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         din_meta_ff <= 1'b0;
         din_sync_ff <= 1'b0;
      end
      else
      begin
         din_meta_ff <= link.pin_level;
         din_sync_ff <= din_meta_ff;
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= ST_IDLE;
         cnt_ff <= '0;
         bit_ff <= '0;
         tx_ff <= '0;
         rx_ff <= '0;
         sclk_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         ready_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_ff <= '0;
      end
      else
      begin
         rsp_valid_ff <= 1'b0;
         cnt_ff <= cnt_ff + 4'h1;
         case (state_ff)
            ST_IDLE:
            begin
               ready_ff <= 1'b1;
               if (cmd_valid && ready_ff)
               begin
                  ready_ff <= 1'b0;
                  tx_ff <= cmd_word;
                  cs_n_ff <= 1'b0;
                  cnt_ff <= '0;
                  bit_ff <= '0;
                  state_ff <= ST_LEAD;
               end
            end
            ST_LEAD, ST_LOW:
               if (half_done)
               begin
                  sclk_ff <= 1'b1;
                  rx_ff <= {rx_ff[`WORD_BITS-2:0], din_sync_ff};
                  cnt_ff <= '0;
                  state_ff <= ST_HIGH;
               end
            ST_HIGH:
               if (half_done)
               begin
                  sclk_ff <= 1'b0;
                  cnt_ff <= '0;
                  if (last_bit)
                     state_ff <= ST_TRAIL;
                  else
                  begin
                     tx_ff <= {tx_ff[`WORD_BITS-2:0], 1'b0};
                     bit_ff <= bit_ff + 5'h01;
                     state_ff <= ST_LOW;
                  end
               end
            ST_TRAIL:
               if (half_done)
               begin
                  cs_n_ff <= 1'b1;
                  cnt_ff <= '0;
                  state_ff <= ST_GAP;
               end
            ST_GAP:
               if (gap_done)
               begin
                  rsp_valid_ff <= 1'b1;
                  rsp_ff <= rx_ff;
                  state_ff <= ST_IDLE;
               end
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.sclk = sclk_ff;
   assign link.cs_n = cs_n_ff;
   assign link.sdi = tx_ff[`WORD_BITS-1];
   assign cmd_ready = ready_ff;
   assign rsp_valid = rsp_valid_ff;
   assign rsp_word = rsp_ff;

endmodule
`default_nettype wire

/* test/led_serial_sva.sv */
// Purpose: Concurrent checks on the link between serial host and device.
// Assumes: Link signals are sampled on clk; the host makes sclk from clk.
// Notes: Watches the first link only, where both ends are design code.
`timescale 1ns/1ps
`default_nettype none
module led_serial_sva
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic pin_out,
   input wire logic pin_oe_n
);
   // ------------------------------------------------------------
   // Rising serial clock count within a frame
   // ------------------------------------------------------------
   logic sclk_q_ff;
   logic [4:0] rise_cnt_ff;
   wire logic sclk_rise;
   wire logic [4:0] nxt_rise_cnt;

   assign sclk_rise = sclk & ~sclk_q_ff;
   assign nxt_rise_cnt = cs_n ? 5'h0 : rise_cnt_ff + {4'h0, sclk_rise};

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclk_q_ff <= 1'b0;
         rise_cnt_ff <= 5'h0;
      end
      else
      begin
         sclk_q_ff <= sclk;
         rise_cnt_ff <= nxt_rise_cnt;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence lead_seq;
      !sclk [*4] ##1 sclk;
   endsequence

   sequence gap_seq;
      cs_n [*5];
   endsequence

   AST_FRAME_LEAD:
   assert property ($fell(cs_n) |-> lead_seq)
      else $error("serial clock not low for four clocks at frame start");
   AST_CS_GAP:
   assert property ($rose(cs_n) |-> gap_seq)
      else $error("chip select high for fewer than five clocks");
   AST_IDLE_CLOCK:
   assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("serial clock high while deselected");
   AST_WORD_LENGTH:
   assert property ($rose(cs_n) |-> rise_cnt_ff == 5'h10)
      else $error("frame did not carry sixteen rising clocks");
   AST_DIN_STABLE:
   assert property ($rose(sclk) |-> $stable(sdi))
      else $error("serial input moved at the sampling edge");
   AST_OUT_ON_FALL:
   assert property ($changed(pin_out) |-> $fell(sclk) && !cs_n)
      else $error("serial output changed away from a falling clock");
   AST_OUT_DRIVEN:
   assert property (!pin_oe_n)
      else $error("serial output released");
   AST_DESELECT_HOLD:
   assert property (cs_n ##1 cs_n |-> $stable(pin_out))
      else $error("serial output moved while deselected");
endmodule
`default_nettype wire

/* test/led_driver_serial_port_test.sv */
// Purpose: Self-checking bench for the serial host and LED device pair.
// Assumes: The host makes sclk; two links, one per device variant.
// Notes: Link b carries the variant whose pin starts as PWM input.
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_port_test import led_serial_pkg::*;;
   logic clk = 1'b0;
   logic arst_n = 1'b1;
   logic [1:0] cmd_valid = 2'h0;
   word_t cmd_word = 16'h0000;
   logic pwm_b = 1'b0;
   wire logic [1:0] cmd_ready;
   wire logic [1:0] rsp_valid;
   wire logic [15:0] rsp_a;
   wire logic [15:0] rsp_b;
   wire logic [15:0] latched_word;
   wire logic wr_pulse;
   wire logic [6:0] wr_addr;
   wire logic [7:0] wr_data;
   wire logic [1:0] pin_is_sout;
   wire logic [1:0] pwm_in;
   int errors = 0;
   int tests_run = 0;
   int wr_seen = 0;
   // Each reply carries the previous word, with a read's byte merged in.
   word_t cmds [7] = '{16'h1055, 16'h2acd, 16'haa00, 16'h1234, 16'h9000,
      16'haa00, 16'h0000};
   word_t rsps [7] = '{16'h0000, 16'h1055, 16'h2acd, 16'haacd, 16'h1234,
      16'h9055, 16'haacd};

   led_serial_if link_a ();
   led_serial_if link_b ();
   assign link_a.pwm_src = 1'b0;
   assign link_b.pwm_src = pwm_b;

   led_serial_host led_serial_host_inst (.clk(clk), .arst_n(arst_n),
      .link(link_a), .cmd_valid(cmd_valid[0]), .cmd_word(cmd_word),
      .cmd_ready(cmd_ready[0]), .rsp_valid(rsp_valid[0]), .rsp_word(rsp_a));
   led_serial_device led_serial_device_inst (.clk(clk), .arst_n(arst_n),
      .link(link_a), .latched_word(latched_word), .wr_pulse(wr_pulse),
      .wr_addr(wr_addr), .wr_data(wr_data), .pin_is_sout(pin_is_sout[0]),
      .pwm_clock_input(pwm_in[0]));
   led_serial_host led_serial_host_inst_b (.clk(clk), .arst_n(arst_n),
      .link(link_b), .cmd_valid(cmd_valid[1]), .cmd_word(cmd_word),
      .cmd_ready(cmd_ready[1]), .rsp_valid(rsp_valid[1]), .rsp_word(rsp_b));
   led_serial_device #(.PIN_STARTS_AS_SOUT(1'b0)) led_serial_device_inst_b (
      .clk(clk), .arst_n(arst_n), .link(link_b), .latched_word(),
      .wr_pulse(), .wr_addr(), .wr_data(), .pin_is_sout(pin_is_sout[1]),
      .pwm_clock_input(pwm_in[1]));
   led_serial_sva led_serial_sva_inst (.clk(clk), .arst_n(arst_n),
      .sclk(link_a.sclk), .cs_n(link_a.cs_n), .sdi(link_a.sdi),
      .pin_out(link_a.pin_out), .pin_oe_n(link_a.pin_oe_n));

   always #12.5 clk = ~clk;

   always @(negedge clk)
      if (wr_pulse === 1'b1)
         wr_seen++;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check_word(input string what, input word_t exp,
      input word_t got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_flag(input string what, input logic exp,
      input logic got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Holds the request one edge, then waits a bounded time for the reply.
   task automatic send(input int idx, input word_t w, output word_t rsp);
      int n;
      n = 0;
      while (cmd_ready[idx] !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      cmd_word = w;
      cmd_valid[idx] = 1'b1;
      @(negedge clk);
      cmd_valid[idx] = 1'b0;
      while (rsp_valid[idx] !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 400)
         errors++;
      rsp = idx ? rsp_b : rsp_a;
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial
   begin
      word_t got;
      logic [14:0] last_wr;
      int wr_exp;
      last_wr = 15'h0;
      wr_exp = 0;
      // Reset is entered by an edge so that flops clocked only by the
      // serial clock see it too, not just those on clk.
      #1 arst_n = 1'b0;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      check_flag("pin a", 1'b1, pin_is_sout[0]);
      check_flag("pin b", 1'b0, pin_is_sout[1]);
      check_flag("drive b", 1'b1, link_b.pin_oe_n);
      check_flag("pwm a", 1'b0, pwm_in[0]);
      check_word("latch at reset", 16'h0000, latched_word);
      for (int i = 0; i < 7; i++)
      begin
         send(0, cmds[i], got);
         if (!cmds[i][15])
         begin
            last_wr = cmds[i][14:0];
            wr_exp++;
         end
         check_word("reply", rsps[i], got);
         check_word("latched", cmds[i], latched_word);
         check_word("fields", {1'b0, last_wr},
            {1'b0, wr_addr, wr_data});
         check_word("writes", wr_exp[15:0], wr_seen[15:0]);
      end
      pwm_b = 1'b1;
      repeat (4) @(negedge clk);
      check_flag("pwm input", 1'b1, pwm_in[1]);
      send(1, 16'h1000, got);
      check_word("reply before config", 16'hffff, got);
      check_flag("pin after config", 1'b1, pin_is_sout[1]);
      check_flag("pwm forced low", 1'b0, pwm_in[1]);
      send(1, 16'h9000, got);
      check_word("echo b", 16'h1000, got);
      send(1, 16'h0000, got);
      check_word("config readback", 16'h9000, got);
      end_sim();
   end

   // Ten frames of about 150 clocks each fit well inside this span.
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
